// ===== pin_sync3.sv
// three-stage synchroniser for a level arriving from outside the clock domain
`timescale 1ns/1ps
module pin_sync3
	import usb_ep_pkg::*;
(
	input wire logic i_clk_sys,
	input wire logic i_nrst,
	input wire logic i_pin,
	output logic o_level
);

	typedef struct packed {
		logic [2:0] ff;
		logic level;
	} sync_state_type;

	sync_state_type s_r;
	sync_state_type s_nxt;

	always_comb
	begin
		s_nxt = s_r;
		s_nxt.ff = {s_r.ff[1:0], i_pin};
		// first stage feeds only the second; the level moves once stages two and three agree
		if (s_r.ff[1] == s_r.ff[2])
		begin
			s_nxt.level = s_r.ff[2];
		end
	end

	always_ff @(posedge i_clk_sys)
	begin
		if (!i_nrst)
		begin
			s_r <= '0;
		end
		else
		begin
			s_r <= s_nxt;
		end
	end

	assign o_level = s_r.level;

endmodule : pin_sync3

// ===== usb_endpoint_control_status.sv
// endpoint configuration and status registers with serial-engine handshake decisions
`timescale 1ns/1ps
module usb_endpoint_control_status
	import usb_ep_pkg::*;
(
	input wire logic i_clk_sys,
	input wire logic i_nrst,
	input wire logic i_usb_bus_reset,
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic i_wb_we,
	input wire logic [11:0] i_wb_adr,
	input wire logic [3:0] i_wb_sel,
	input wire logic [31:0] i_wb_dat,
	output logic o_wb_ack,
	output logic [31:0] o_wb_dat,
	input wire sie_event_type i_sie,
	output sie_resp_type o_sie_resp,
	output logic o_irq
);

	typedef struct packed {
		ep_state_type [EP_COUNT-1:0] ep;
		logic [3:0] selector;
		logic [6:0] irq_status;
		logic [6:0] irq_mask;
		logic wb_ack;
		logic [31:0] wb_dat;
		sie_resp_type resp;
		logic irq;
	} state_type;

	state_type s_r;
	state_type s_nxt;
	logic bus_reset_level;
	wb_req_type wb;

	// bus reset comes from the line detector, outside this clock
	pin_sync3 u_bus_reset_sync (
		.i_clk_sys(i_clk_sys),
		.i_nrst(i_nrst),
		.i_pin(i_usb_bus_reset),
		.o_level(bus_reset_level)
	);

	assign wb = '{cyc: i_wb_cyc, stb: i_wb_stb, we: i_wb_we, adr: i_wb_adr,
		sel: i_wb_sel, dat: i_wb_dat};

	function automatic logic [7:0] config_byte(input ep_state_type e, input logic [3:0] idx);
		logic [7:0] v;
		v = 8'h00;
		v[CFG_ACTIVE_BIT] = e.endpoint_active;
		v[CFG_TOGGLE_BIT] = e.toggle_state;
		v[CFG_WAY_BIT] = e.transfer_way_select;
		v[CFG_KIND_LSB +: 2] = kind_eff(e, idx);
		return v;
	endfunction : config_byte

	function automatic logic [7:0] status_byte(input ep_state_type e);
		logic [7:0] v;
		v = 8'h00;
		v[STA_CTL_DIR_BIT] = e.ctl_dir;
		v[STA_BANK1_BIT] = e.bank1_out_received;
		v[STA_STALL_BIT] = e.stall_request;
		return v;
	endfunction : status_byte

	function automatic state_type reset_state();
		state_type r;
		r = '0;
		for (int i = 0; i < EP_COUNT; i++)
		begin
			r.ep[i] = ep_reset_value(i);
		end
		r.selector = SEL_RST;
		r.irq_status = IRQ_RST;
		r.irq_mask = IRQ_RST;
		r.resp = '{valid: 1'b0, hs: HS_NONE};
		return r;
	endfunction : reset_state

	always_comb
	begin
		logic access;
		logic sel_ok;
		logic [9:0] idx;
		logic [2:0] sel_ep;
		logic [2:0] sie_ep;
		logic sie_ok;
		ep_state_type e;
		logic [1:0] k;
		access = 1'b0;
		sel_ok = 1'b0;
		idx = 10'h000;
		sel_ep = 3'h0;
		sie_ep = 3'h0;
		sie_ok = 1'b0;
		e = '0;
		k = KIND_CONTROL;
		s_nxt = s_r;
		s_nxt.wb_ack = 1'b0;
		s_nxt.resp.valid = 1'b0;
		s_nxt.resp.hs = HS_NONE;

		// classic single cycle: one-cycle ack, dropped the cycle after
		access = wb.cyc && wb.stb && !s_r.wb_ack;
		idx = wb.adr[11:2];
		sel_ok = (s_r.selector <= EP_LAST);
		sel_ep = s_r.selector[2:0];
		if (access)
		begin
			s_nxt.wb_ack = 1'b1;
			s_nxt.wb_dat = 32'h0000_0000;
			if (!wb.we)
			begin
				case (idx)
					IDX_SELECTOR: s_nxt.wb_dat[3:0] = s_r.selector;
					IDX_CONFIG:
					begin
						if (sel_ok)
						begin
							s_nxt.wb_dat[7:0] = config_byte(s_r.ep[sel_ep], s_r.selector);
						end
					end
					IDX_STATUS:
					begin
						if (sel_ok)
						begin
							s_nxt.wb_dat[7:0] = status_byte(s_r.ep[sel_ep]);
						end
					end
					IDX_IRQ_STATUS: s_nxt.wb_dat[6:0] = s_r.irq_status;
					IDX_IRQ_MASK: s_nxt.wb_dat[6:0] = s_r.irq_mask;
					default: s_nxt.wb_dat = 32'h0000_0000;
				endcase
			end
			else if (wb.sel[0])
			begin
				case (idx)
					IDX_SELECTOR: s_nxt.selector = wb.dat[3:0];
					IDX_CONFIG:
					begin
						if (sel_ok)
						begin
							// toggle is read-only; reserved bits are not stored
							s_nxt.ep[sel_ep].endpoint_active = wb.dat[CFG_ACTIVE_BIT];
							s_nxt.ep[sel_ep].transfer_way_select = wb.dat[CFG_WAY_BIT];
							if (s_r.selector != 4'h0)
							begin
								s_nxt.ep[sel_ep].endpoint_kind = wb.dat[CFG_KIND_LSB +: 2];
							end
						end
					end
					IDX_STATUS:
					begin
						if (sel_ok)
						begin
							s_nxt.ep[sel_ep].ctl_dir = wb.dat[STA_CTL_DIR_BIT];
							s_nxt.ep[sel_ep].stall_request = wb.dat[STA_STALL_BIT];
							// firmware may only clear the bank flag, never set it
							if (!wb.dat[STA_BANK1_BIT])
							begin
								s_nxt.ep[sel_ep].bank1_out_received = 1'b0;
							end
						end
					end
					IDX_IRQ_STATUS: s_nxt.irq_status = s_r.irq_status & ~wb.dat[6:0];
					IDX_IRQ_MASK: s_nxt.irq_mask = wb.dat[6:0];
					default: s_nxt.selector = s_nxt.selector;
				endcase
			end
		end

		// hardware events come after the bus so a set in the clear cycle wins
		sie_ok = (i_sie.ep <= EP_LAST);
		sie_ep = i_sie.ep[2:0];
		if (sie_ok)
		begin
			e = s_r.ep[sie_ep];
			k = kind_eff(e, i_sie.ep);
			if (e.endpoint_active)
			begin
				if (i_sie.pkt_ok)
				begin
					s_nxt.ep[sie_ep].toggle_state = !i_sie.pkt_data1;
				end
				if (i_sie.bank1_stored)
				begin
					s_nxt.ep[sie_ep].bank1_out_received = 1'b1;
					s_nxt.irq_status[sie_ep] = 1'b1;
				end
			end
		end

		if (i_sie.token)
		begin
			s_nxt.resp.valid = 1'b1;
			if (!sie_ok || !e.endpoint_active)
			begin
				s_nxt.resp.hs = HS_NONE;
			end
			else if (k != KIND_CONTROL && e.transfer_way_select != i_sie.token_in)
			begin
				// direction bit only matters off control
				s_nxt.resp.hs = HS_NONE;
			end
			else if (e.stall_request)
			begin
				s_nxt.resp.hs = HS_STALL;
			end
			else if (!i_sie.token_in && i_sie.token_bank1 && e.bank1_out_received
				&& k != KIND_ISO)
			begin
				s_nxt.resp.hs = HS_NAK;
			end
			else
			begin
				s_nxt.resp.hs = HS_ACK;
			end
		end

		s_nxt.irq = |(s_nxt.irq_status & s_nxt.irq_mask);
	end

	always_ff @(posedge i_clk_sys)
	begin
		if (!i_nrst || bus_reset_level)
		begin
			s_r <= reset_state();
		end
		else
		begin
			s_r <= s_nxt;
		end
	end

	assign o_wb_ack = s_r.wb_ack;
	assign o_wb_dat = s_r.wb_dat;
	assign o_sie_resp = s_r.resp;
	assign o_irq = s_r.irq;

endmodule : usb_endpoint_control_status

// ===== usb_endpoint_control_status_bench.sv
// self-checking bench of the endpoint configuration and status block
`timescale 1ns/1ps
module usb_endpoint_control_status_bench
	import usb_ep_pkg::*;
;
	logic clk = 0, nrst = 0, bres = 0, ack, irq;
	logic [31:0] dat;
	logic [7:0] v;
	logic [3:0] e;
	logic [7:0] fx [0:6] = '{8'h84, 8'h82, 8'h81, 8'h02, 8'h87, 8'h83, 8'h85};
	wb_req_type rq = '0;
	sie_event_type sie;
	sie_resp_type resp;
	int seed = 32'h83C095D1, num_errors = 0, total_checks = 0;
	always #5 clk = ~clk;
	usb_host_model i_usb_host_model (.i_clk_sys(clk), .o_sie(sie));
	usb_endpoint_control_status i_usb_endpoint_control_status (.i_clk_sys(clk),
		.i_nrst(nrst), .i_usb_bus_reset(bres), .i_wb_cyc(rq.cyc), .i_wb_stb(rq.stb),
		.i_wb_we(rq.we), .i_wb_adr(rq.adr), .i_wb_sel(rq.sel), .i_wb_dat(rq.dat),
		.o_wb_ack(ack), .o_wb_dat(dat), .i_sie(sie), .o_sie_resp(resp), .o_irq(irq));
	function automatic logic [7:0] cfg_rd(input logic [3:0] ep, input logic [7:0] w);
		return (ep == 4'h0) ? (w & 8'h84) : (w & 8'h87);
	endfunction : cfg_rd
	task results;
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : results
	task chk(input string nm, input logic [31:0] x, input logic [31:0] g);
		total_checks++;
		if (g !== x)
		begin
			num_errors++;
			$display("unexpected %s: expected %h seen %h", nm, x, g);
		end
	endtask : chk
	task bus(input logic w, input logic [9:0] a, input logic [7:0] d, output logic [31:0] q);
		rq <= '{1'b1, 1'b1, w, {a, 2'h0}, 4'hF, {24'h0, d}};
		@(posedge clk);
		// no fixed latency assumed; only the watchdog ends a hung wait
		while (ack !== 1'b1)
			@(posedge clk);
		q = dat;
		rq <= '0;
		@(posedge clk);
	endtask : bus
	task wr(input logic [9:0] a, input logic [7:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask : wr
	task rdc(input logic [9:0] a, input logic [7:0] x);
		logic [31:0] q;
		bus(1'b0, a, 8'h00, q);
		chk("register", {24'h0, x}, q);
	endtask : rdc
	task tok(input logic [3:0] ep, input logic i, input logic b, input hs_type h);
		i_usb_host_model.send(ep, {4'h1, i, b});
		@(posedge clk);
		chk("handshake", {29'h0, 1'b1, h}, {29'h0, resp});
	endtask : tok
	initial
	begin
		#100000;
		num_errors++;
		results;
	end
	initial
	begin
		repeat (12) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		for (e = 0; e < 4'h8; e++)
		begin
			wr(IDX_SELECTOR, {4'h0, e});
			rdc(IDX_CONFIG, (e == 0) ? CFG_RST_EP0 : CFG_RST_OTHER);
			rdc(IDX_STATUS, 8'h00);
		end
		for (e = 0; e < 4'h7; e++)
		begin
			v = 8'($random(seed)) & 8'h8F;
			wr(IDX_SELECTOR, {4'h0, e});
			wr(IDX_CONFIG, v);
			rdc(IDX_CONFIG, cfg_rd(e, v));
			wr(IDX_CONFIG, fx[e]);
		end
		wr(IDX_SELECTOR, 8'h03);
		i_usb_host_model.send(4'h3, 6'h20);
		rdc(IDX_CONFIG, 8'h02);
		wr(IDX_SELECTOR, 8'h01);
		repeat (4)
		begin
			v = 8'($random(seed));
			i_usb_host_model.send(4'h1, {1'b1, v[0], 4'h0});
			rdc(IDX_CONFIG, {4'h8, ~v[0], 3'h2});
		end
		tok(4'h1, 1'b0, 1'b0, HS_ACK);
		tok(4'h1, 1'b1, 1'b0, HS_NONE);
		tok(4'h4, 1'b1, 1'b0, HS_ACK);
		tok(4'h3, 1'b0, 1'b0, HS_NONE);
		tok(4'h0, 1'b0, 1'b0, HS_ACK);
		tok(4'h0, 1'b1, 1'b0, HS_ACK);
		i_usb_host_model.send(4'h1, 6'h08);
		rdc(IDX_STATUS, 8'h40);
		chk("irq", 0, {31'h0, irq});
		tok(4'h1, 1'b0, 1'b1, HS_NAK);
		tok(4'h1, 1'b0, 1'b0, HS_ACK);
		wr(IDX_IRQ_MASK, 8'h02);
		chk("irq", 1, {31'h0, irq});
		wr(IDX_IRQ_STATUS, 8'h02);
		chk("irq", 0, {31'h0, irq});
		wr(IDX_STATUS, 8'hA0);
		rdc(IDX_STATUS, 8'hA0);
		tok(4'h1, 1'b0, 1'b1, HS_STALL);
		i_usb_host_model.send(4'h2, 6'h08);
		tok(4'h2, 1'b0, 1'b1, HS_ACK);
		rdc(10'h0F0, 8'h00);
		wr(IDX_IRQ_MASK, 8'h06);
		chk("irq", 1, {31'h0, irq});
		bres <= 1'b1;
		repeat (10) @(posedge clk);
		bres <= 1'b0;
		repeat (10) @(posedge clk);
		chk("irq", 0, {31'h0, irq});
		rdc(IDX_IRQ_STATUS, 8'h00);
		rdc(IDX_CONFIG, 8'h80);
		wr(IDX_SELECTOR, 8'h01);
		rdc(IDX_CONFIG, 8'h00);
		rdc(IDX_STATUS, 8'h00);
		results;
	end
endmodule : usb_endpoint_control_status_bench

// ===== usb_endpoint_control_status_monitor.sv
// port checker of the endpoint configuration and status block
`timescale 1ns/1ps
module usb_endpoint_control_status_monitor
	import usb_ep_pkg::*;
(
	input wire logic i_clk_sys,
	input wire logic i_nrst,
	input wire logic i_usb_bus_reset,
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic i_wb_we,
	input wire sie_event_type i_sie,
	input wire logic o_wb_ack,
	input wire logic [31:0] o_wb_dat,
	input wire sie_resp_type o_sie_resp,
	input wire logic o_irq
);
	default clocking cb @(posedge i_clk_sys);
	endclocking
	default disable iff (!i_nrst);
	chk_ack_follows_req: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
		else $error("ack missing after request");
	chk_ack_one_cycle: assert property (o_wb_ack |=> !o_wb_ack)
		else $error("ack longer than one cycle");
	chk_ack_has_cause: assert property (o_wb_ack |-> $past(i_wb_cyc && i_wb_stb))
		else $error("ack without request");
	chk_read_upper_zero: assert property (o_wb_ack |-> o_wb_dat[31:8] == 24'h0)
		else $error("read data upper bits set");
	chk_token_answer: assert property (i_sie.token && i_sie.ep <= EP_LAST |=> o_sie_resp.valid)
		else $error("token not answered");
	chk_resp_has_token: assert property (o_sie_resp.valid |-> $past(i_sie.token))
		else $error("answer without token");
	chk_irq_rise_cause: assert property ($rose(o_irq) |-> $past(i_sie.bank1_stored || i_wb_we))
		else $error("interrupt rose without cause");
	chk_bus_reset_quiet: assert property (i_usb_bus_reset [*8] |-> !o_irq && !o_sie_resp.valid)
		else $error("activity during bus reset");
	cov_stall: cover property (o_sie_resp.valid && o_sie_resp.hs == HS_STALL);
	cov_nak: cover property (o_sie_resp.valid && o_sie_resp.hs == HS_NAK);
	cov_irq: cover property ($rose(o_irq));
endmodule : usb_endpoint_control_status_monitor
bind usb_endpoint_control_status usb_endpoint_control_status_monitor i_mon (.i_clk_sys, .i_nrst,
	.i_usb_bus_reset, .i_wb_cyc, .i_wb_stb, .i_wb_we, .i_sie, .o_wb_ack, .o_wb_dat,
	.o_sie_resp, .o_irq);

// ===== usb_ep_pkg.sv
// constants, types and helpers of the endpoint configuration and status block
package usb_ep_pkg;

	localparam int EP_COUNT = 7;
	localparam logic [3:0] EP_LAST = 4'h6;

	// register indices; the byte address on the bus is four times the index
	localparam logic [9:0] IDX_SELECTOR = 10'h0C7;
	localparam logic [9:0] IDX_STATUS = 10'h0CE;
	localparam logic [9:0] IDX_CONFIG = 10'h0D4;
	localparam logic [9:0] IDX_IRQ_STATUS = 10'h0E0;
	localparam logic [9:0] IDX_IRQ_MASK = 10'h0E1;

	// endpoint_config fields
	localparam int CFG_ACTIVE_BIT = 7;
	localparam int CFG_TOGGLE_BIT = 3;
	localparam int CFG_WAY_BIT = 2;
	localparam int CFG_KIND_LSB = 0;
	localparam logic [7:0] CFG_RST_EP0 = 8'h80;
	localparam logic [7:0] CFG_RST_OTHER = 8'h00;

	// endpoint_status fields
	localparam int STA_CTL_DIR_BIT = 7;
	localparam int STA_BANK1_BIT = 6;
	localparam int STA_STALL_BIT = 5;

	localparam logic [1:0] KIND_CONTROL = 2'h0;
	localparam logic [1:0] KIND_ISO = 2'h1;
	localparam logic [1:0] KIND_BULK = 2'h2;
	localparam logic [1:0] KIND_INTR = 2'h3;

	localparam logic [6:0] IRQ_RST = 7'h00;
	localparam logic [3:0] SEL_RST = 4'h0;

	typedef enum logic [1:0] {HS_NONE, HS_ACK, HS_NAK, HS_STALL} hs_type;

	typedef struct packed {
		logic endpoint_active;
		logic toggle_state;
		logic transfer_way_select;
		logic [1:0] endpoint_kind;
		logic ctl_dir;
		logic bank1_out_received;
		logic stall_request;
	} ep_state_type;

	// events from the serial engine, same clock domain
	typedef struct packed {
		logic [3:0] ep;
		logic pkt_ok;
		logic pkt_data1;
		logic bank1_stored;
		logic token;
		logic token_in;
		logic token_bank1;
	} sie_event_type;

	typedef struct packed {
		logic valid;
		hs_type hs;
	} sie_resp_type;

	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [11:0] adr;
		logic [3:0] sel;
		logic [31:0] dat;
	} wb_req_type;

	function automatic ep_state_type ep_reset_value(input int idx);
		ep_state_type e;
		logic [7:0] v;
		v = (idx == 0) ? CFG_RST_EP0 : CFG_RST_OTHER;
		e = '0;
		e.endpoint_active = v[CFG_ACTIVE_BIT];
		e.toggle_state = v[CFG_TOGGLE_BIT];
		e.transfer_way_select = v[CFG_WAY_BIT];
		e.endpoint_kind = v[CFG_KIND_LSB +: 2];
		return e;
	endfunction : ep_reset_value

	// endpoint 0 always acts as control whatever was stored
	function automatic logic [1:0] kind_eff(input ep_state_type e, input logic [3:0] idx);
		return (idx == 4'h0) ? KIND_CONTROL : e.endpoint_kind;
	endfunction : kind_eff

endpackage : usb_ep_pkg

// ===== usb_host_model.sv
// host-side model driving the serial engine events
`timescale 1ns/1ps
module usb_host_model
	import usb_ep_pkg::*;
(
	input wire logic i_clk_sys,
	output sie_event_type o_sie
);
	initial o_sie = '0;
	// f: pkt_ok, data1, bank1 stored, token, token in, bank1 aimed
	task send(input logic [3:0] ep, input logic [5:0] f);
		o_sie <= {ep, f};
		@(posedge i_clk_sys);
		// idle index is scrambled so a stale value is never trusted
		o_sie <= {~ep, 6'h0};
	endtask : send
endmodule : usb_host_model
